// >>> hdl/tmr_core.sv
/*
 Timer core: 8/16-bit up counter with mode decode, overflow and compare
 flags, capture into the compare registers, and the byte bus register file
 with a shared high-byte latch for 16-bit transfers.
 Assumes a byte master on the same clock: one-cycle strobes, read data in
 the cycle after the read strobe, and interrupt acknowledges as pulses.
*/
// Functional notes
// - Three control bits pick the operating mode
// - Normal 8-bit counts per tick, wraps 0xFF
// - Overflow flag set on wrap to zero
// - Interrupt acknowledge clears the overflow flag
// - Counter writable at any time in normal modes
// - Clear-on-match clears counter at compare A
// - Clear-on-match sets compare flag A at top
// - Compare A writes act at once, unbuffered
// - Overflow in clear-on-match as normal mode
// - 16-bit mode wraps 0xFFFF, sets overflow
// - 8-bit capture runs free to 0xFF
// - 16-bit capture runs free, overflow at max
// - Tick is a clock enable, one clock
// - One shared high-byte latch for wide access
// - Low byte write loads latch plus byte
// - Low byte read copies high byte to latch
// - Compare and 8-bit capture readable direct; 16-bit capture through latch
// - Compare flag set on tick after equality
// - Counter write blocks match at next tick
// - Counter write beats count and clear
// - Source zero stops ticks, counter still accessible
`timescale 1ns/100ps
`include "tmr_defines.svh"

module tmr_core
	import tmr_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_nrst,
	// Register bus
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// Interrupt acknowledges from the core
	input  wire logic       i_ovf_ack,
	input  wire logic       i_cmpa_ack,
	input  wire logic       i_cmpb_ack,
	// Capture front end
	input  wire logic       i_capture,
	// External count pin
	input  wire logic       i_ext_tick_pin,
	// Flags
	output logic            o_overflow_flag,
	output logic            o_compare_flag_a,
	output logic            o_compare_flag_b
);

	// Mode decode from the three control bits
	function automatic tmr_mode_t f_mode(input logic wide, input logic cap, input logic clr);
		tmr_mode_t m;
		m = TMR_MODE_NORM8;
		if (cap && wide) begin
			m = TMR_MODE_CAP16;
		end else if (cap) begin
			m = TMR_MODE_CAP8;
		end else if (wide) begin
			m = TMR_MODE_NORM16;
		end else if (clr) begin
			m = TMR_MODE_CTC8;
		end
		return m;
	endfunction

	// Register state
	logic        width_select;          // 16-bit operation
	logic        capture_mode_enable;   // Capture into compare registers
	logic        clear_on_match_select; // Clear on compare A
	logic [2:0]  tick_source_select;    // Tick source, zero stops
	logic [15:0] cnt;                   // Count, high and low bytes
	logic [7:0]  compare_reg_a;         // Compare A, low byte when wide
	logic [7:0]  compare_reg_b;         // Compare B, high byte when wide
	logic [7:0]  high_byte_latch;       // Shared by all wide registers
	logic        blk;                   // Match blocked at next tick
	logic [7:0]  rdata;

	// Next values
	logic        next_width_select;
	logic        next_capture_mode_enable;
	logic        next_clear_on_match_select;
	logic [2:0]  next_tick_source_select;
	logic [15:0] next_cnt;
	logic [7:0]  next_compare_reg_a;
	logic [7:0]  next_compare_reg_b;
	logic [7:0]  next_high_byte_latch;
	logic        next_blk;
	logic [7:0]  next_rdata;
	logic        next_ovf;
	logic        next_cmpa;
	logic        next_cmpb;

	// Decoded conditions
	tmr_mode_t   mode;
	logic        timer_tick;            // Clock enable from the tick generator, prescaler or pin
	logic        wr_cnt;                // Processor writes the counter
	logic        ovf_set;
	logic        cmpa_set;
	logic        cmpb_set;

	assign mode   = f_mode(width_select, capture_mode_enable, clear_on_match_select);
	assign wr_cnt = i_wr && (i_addr == `TMR_ADDR_CNT_LO);

	// Tick source; an enable only, the counter stays on the system clock
	tmr_tick_gen u_tick (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_src     (tick_source_select),
		.i_ext_pin (i_ext_tick_pin),
		.o_tick    (timer_tick)
	);

	// Event detection at the tick, on the value before it advances
	always_comb begin
		ovf_set  = 1'b0;
		cmpa_set = 1'b0;
		cmpb_set = 1'b0;
		if (timer_tick && !wr_cnt) begin
			// Overflow only when passing the true maximum
			ovf_set = width_select ? (cnt == `TMR_MAX16) : (cnt[7:0] == `TMR_MAX8);
		end
		// Match seen during the count period flags at the tick ending it
		if (timer_tick && !blk && !wr_cnt) begin
			case (mode)
				TMR_MODE_NORM8, TMR_MODE_CTC8: begin
					cmpa_set = (cnt[7:0] == compare_reg_a);
					cmpb_set = (cnt[7:0] == compare_reg_b);
				end
				// Compare A acts as capture store here
				TMR_MODE_CAP8:   cmpb_set = (cnt[7:0] == compare_reg_b);
				TMR_MODE_NORM16: cmpa_set = (cnt == {compare_reg_b, compare_reg_a});
				// No free compare registers in wide capture
				TMR_MODE_CAP16:  cmpa_set = 1'b0;
				default:         cmpa_set = 1'b0;
			endcase
		end
	end

	// Next state of counter, registers, latch and flags
	always_comb begin
		next_width_select          = width_select;
		next_capture_mode_enable   = capture_mode_enable;
		next_clear_on_match_select = clear_on_match_select;
		next_tick_source_select    = tick_source_select;
		next_cnt                   = cnt;
		next_compare_reg_a         = compare_reg_a;
		next_compare_reg_b         = compare_reg_b;
		next_high_byte_latch       = high_byte_latch;
		next_ovf                   = o_overflow_flag;
		next_cmpa                  = o_compare_flag_a;
		next_cmpb                  = o_compare_flag_b;
		next_rdata                 = `TMR_ZERO8;
		// Block holds until the tick that it covers
		next_blk = wr_cnt ? 1'b1 : (timer_tick ? 1'b0 : blk);

		// Capture stores the count; a processor write below wins
		if (i_capture && capture_mode_enable) begin
			next_compare_reg_a = cnt[7:0];
			if (width_select) begin
				next_compare_reg_b = cnt[15:8];
			end
		end

		// Counting on the tick enable
		if (timer_tick) begin
			if (width_select) begin
				next_cnt = cnt + `TMR_ONE16;
			end else if ((mode == TMR_MODE_CTC8) && (cnt[7:0] == compare_reg_a)) begin
				next_cnt[7:0] = `TMR_ZERO8;
			end else begin
				// 8-bit add wraps 0xFF to 0x00 by itself
				next_cnt[7:0] = cnt[7:0] + `TMR_ONE8;
			end
		end

		// Bus writes; the counter write overrides the count above
		if (i_wr) begin
			case (i_addr)
				`TMR_ADDR_CTRL_A: begin
					next_width_select          = i_wdata[`TMR_BIT_WIDTH];
					next_capture_mode_enable   = i_wdata[`TMR_BIT_CAPEN];
					next_clear_on_match_select = i_wdata[`TMR_BIT_CLRMATCH];
				end
				`TMR_ADDR_CTRL_B: next_tick_source_select = i_wdata[2:0];
				// High byte always parks in the latch
				`TMR_ADDR_CNT_HI: next_high_byte_latch = i_wdata;
				`TMR_ADDR_CNT_LO: begin
					if (width_select) begin
						next_cnt = {high_byte_latch, i_wdata};
					end else begin
						next_cnt[7:0] = i_wdata;
					end
				end
				`TMR_ADDR_CMP_B: begin
					if (width_select) begin
						next_high_byte_latch = i_wdata;
					end else begin
						next_compare_reg_b = i_wdata;
					end
				end
				`TMR_ADDR_CMP_A: begin
					// Straight into the register, no double buffer
					if (width_select) begin
						next_compare_reg_b = high_byte_latch;
						next_compare_reg_a = i_wdata;
					end else begin
						next_compare_reg_a = i_wdata;
					end
				end
				// Write one to clear
				`TMR_ADDR_FLAGS: begin
					if (i_wdata[`TMR_FLAG_OVF]) next_ovf = 1'b0;
					if (i_wdata[`TMR_FLAG_CMPA]) next_cmpa = 1'b0;
					if (i_wdata[`TMR_FLAG_CMPB]) next_cmpb = 1'b0;
				end
				default: next_rdata = `TMR_ZERO8;
			endcase
		end

		// Interrupt service clears its flag
		if (i_ovf_ack) next_ovf = 1'b0;
		if (i_cmpa_ack) next_cmpa = 1'b0;
		if (i_cmpb_ack) next_cmpb = 1'b0;

		// Hardware sets last, so a set beats a clear in the same cycle
		if (ovf_set) next_ovf = 1'b1;
		if (cmpa_set) next_cmpa = 1'b1;
		if (cmpb_set) next_cmpb = 1'b1;

		// Bus reads and their latch side effects
		if (i_rd) begin
			case (i_addr)
				`TMR_ADDR_CTRL_A: begin
					next_rdata[`TMR_BIT_WIDTH]    = width_select;
					next_rdata[`TMR_BIT_CAPEN]    = capture_mode_enable;
					next_rdata[`TMR_BIT_CLRMATCH] = clear_on_match_select;
				end
				`TMR_ADDR_CTRL_B: next_rdata[2:0] = tick_source_select;
				`TMR_ADDR_CNT_LO: begin
					next_rdata = cnt[7:0];
					if (width_select) next_high_byte_latch = cnt[15:8];
				end
				// Wide mode returns the latch, narrow the live byte
				`TMR_ADDR_CNT_HI: next_rdata = width_select ? high_byte_latch : cnt[15:8];
				`TMR_ADDR_CMP_A: begin
					next_rdata = compare_reg_a;
					if (mode == TMR_MODE_CAP16) next_high_byte_latch = compare_reg_b;
				end
				// Compare values are fixed, so read direct outside wide capture
				`TMR_ADDR_CMP_B: next_rdata = (mode == TMR_MODE_CAP16) ? high_byte_latch : compare_reg_b;
				`TMR_ADDR_FLAGS: begin
					next_rdata[`TMR_FLAG_OVF]  = o_overflow_flag;
					next_rdata[`TMR_FLAG_CMPA] = o_compare_flag_a;
					next_rdata[`TMR_FLAG_CMPB] = o_compare_flag_b;
				end
				// Unmapped reads return zero
				default: next_rdata = `TMR_ZERO8;
			endcase
		end
	end

	// Register everything
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			{width_select, capture_mode_enable, clear_on_match_select} <= `TMR_RST_CTRL;
			tick_source_select <= `TMR_RST_SRC;
			cnt                <= `TMR_ZERO16;
			compare_reg_a      <= `TMR_ZERO8;
			compare_reg_b      <= `TMR_ZERO8;
			high_byte_latch    <= `TMR_ZERO8;
			blk                <= 1'b0;
			rdata              <= `TMR_ZERO8;
			o_overflow_flag    <= 1'b0;
			o_compare_flag_a   <= 1'b0;
			o_compare_flag_b   <= 1'b0;
		end else begin
			width_select          <= next_width_select;
			capture_mode_enable   <= next_capture_mode_enable;
			clear_on_match_select <= next_clear_on_match_select;
			tick_source_select    <= next_tick_source_select;
			cnt                   <= next_cnt;
			compare_reg_a         <= next_compare_reg_a;
			compare_reg_b         <= next_compare_reg_b;
			high_byte_latch       <= next_high_byte_latch;
			blk                   <= next_blk;
			rdata                 <= next_rdata;
			o_overflow_flag       <= next_ovf;
			o_compare_flag_a      <= next_cmpa;
			o_compare_flag_b      <= next_cmpb;
		end
	end

	assign o_rdata = rdata;

	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	sequence s_wr_hi;
		i_wr && (i_addr == `TMR_ADDR_CNT_HI) && width_select;
	endsequence
	sequence s_wr_lo;
		i_wr && (i_addr == `TMR_ADDR_CNT_LO) && width_select;
	endsequence
	sequence s_rd_lo;
		i_rd && (i_addr == `TMR_ADDR_CNT_LO) && width_select;
	endsequence
	sequence s_rd_hi;
		i_rd && (i_addr == `TMR_ADDR_CNT_HI);
	endsequence

	chk_wrap8_zero: assert property (
		timer_tick && !width_select && !wr_cnt && (cnt[7:0] == `TMR_MAX8) |=> (cnt[7:0] == `TMR_ZERO8) && o_overflow_flag
	) else $error("8-bit wrap did not reach zero with overflow");

	chk_wrap16_ovf: assert property (
		timer_tick && width_select && !wr_cnt && (cnt == `TMR_MAX16) |=> (cnt == `TMR_ZERO16) && o_overflow_flag
	) else $error("16-bit wrap did not reach zero with overflow");

	chk_ack_clears_ovf: assert property (
		i_ovf_ack && !ovf_set |=> !o_overflow_flag
	) else $error("overflow flag survived its acknowledge");

	chk_ctc_clear_top: assert property (
		timer_tick && !wr_cnt && (mode == TMR_MODE_CTC8) && (cnt[7:0] == compare_reg_a)
		|=> (cnt[7:0] == `TMR_ZERO8) && (o_compare_flag_a || $past(blk))
	) else $error("clear on match missed at compare A");

	chk_cnt_only_tick: assert property (
		!timer_tick && !wr_cnt |=> $stable(cnt)
	) else $error("counter moved without tick or write");

	chk_src_off_stops: assert property (
		(tick_source_select == `TMR_SRC_OFF) |-> !timer_tick
	) else $error("tick produced with source off");

	chk_write_wins: assert property (
		wr_cnt && !width_select |=> (cnt[7:0] == $past(i_wdata))
	) else $error("counter write lost to count");

	chk_block_match: assert property (
		wr_cnt ##1 (!timer_tick && !i_wr)[*3] ##1 (timer_tick && !i_wr && !o_compare_flag_a && !i_capture)
		|=> !o_compare_flag_a
	) else $error("match not blocked after counter write");

	chk_pair_write: assert property (
		s_wr_hi ##1 (!i_wr && !i_rd) ##1 s_wr_lo |=> cnt == {$past(i_wdata, 3), $past(i_wdata)}
	) else $error("wide write not loaded as one word");

	chk_pair_read: assert property (
		s_rd_lo ##1 (!i_wr && !i_rd) ##1 s_rd_hi |=> o_rdata == $past(cnt[15:8], 3)
	) else $error("wide read high byte not from latch");

	chk_cmp_delay: assert property (
		(mode == TMR_MODE_NORM8) && !timer_tick && !i_wr && !i_cmpb_ack && !o_compare_flag_b
		##1 timer_tick && !blk && !i_wr && (cnt[7:0] == compare_reg_b) |=> o_compare_flag_b
	) else $error("compare B flag not set at tick after equality");

endmodule

// >>> hdl/tmr_defines.svh
/*
 Timer block constants: register offsets, control bit positions,
 flag positions, count limits, tick source codes and divider masks.
 Assumes it is included by its bare name by the core, the tick generator and the bench.
*/
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// Register offsets on the byte bus
`define TMR_ADDR_CTRL_A   8'h00
`define TMR_ADDR_CTRL_B   8'h01
`define TMR_ADDR_CNT_LO   8'h02
`define TMR_ADDR_CNT_HI   8'h03
`define TMR_ADDR_CMP_A    8'h04
`define TMR_ADDR_CMP_B    8'h05
`define TMR_ADDR_FLAGS    8'h06

// Control register A bit positions
`define TMR_BIT_WIDTH     7
`define TMR_BIT_CAPEN     6
`define TMR_BIT_CLRMATCH  0

// Flag register bit positions
`define TMR_FLAG_OVF      0
`define TMR_FLAG_CMPA     1
`define TMR_FLAG_CMPB     2

// Count limits and reset values
`define TMR_MAX8          8'hff
`define TMR_MAX16         16'hffff
`define TMR_ZERO8         8'h00
`define TMR_ZERO16        16'h0000
`define TMR_ONE16         16'h0001
`define TMR_ONE8          8'h01
`define TMR_RST_CTRL      3'h0
`define TMR_RST_SRC       3'h0

// Tick source select codes
`define TMR_SRC_OFF       3'h0
`define TMR_SRC_DIV1      3'h1
`define TMR_SRC_DIV8      3'h2
`define TMR_SRC_DIV64     3'h3
`define TMR_SRC_DIV256    3'h4
`define TMR_SRC_DIV1024   3'h5
`define TMR_SRC_EXT_FALL  3'h6
`define TMR_SRC_EXT_RISE  3'h7

// Prescaler tap masks
`define TMR_PRE_ZERO      10'h000
`define TMR_PRE_ONE       10'h001
`define TMR_PRE_M8        10'h007
`define TMR_PRE_M64       10'h03f
`define TMR_PRE_M256      10'h0ff
`define TMR_PRE_M1024     10'h3ff

`endif

// >>> hdl/tmr_pkg.sv
/*
 Timer block types: the operating mode enumeration.
 Assumes nothing of its surroundings.
*/
package tmr_pkg;

	// Operating modes, one-hot
	typedef enum logic [4:0] {
		TMR_MODE_NORM8  = 5'h01,
		TMR_MODE_CTC8   = 5'h02,
		TMR_MODE_NORM16 = 5'h04,
		TMR_MODE_CAP8   = 5'h08,
		TMR_MODE_CAP16  = 5'h10
	} tmr_mode_t;

endpackage

// >>> hdl/tmr_tick_gen.sv
/*
 Timer tick generator: a free running prescaler and an external pin edge
 detector, producing a one-cycle timer tick enable on the system clock.
 Assumes the external pin is asynchronous to the system clock.
*/
`timescale 1ns/100ps
`include "tmr_defines.svh"

module tmr_tick_gen
	import tmr_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_nrst,
	// Source selection
	input  wire logic [2:0] i_src,
	// External count pin
	input  wire logic       i_ext_pin,
	// Tick enable
	output logic            o_tick
);

	logic [9:0] pre;       // Prescaler count
	logic [9:0] next_pre;
	logic       sync1;     // Pin synchroniser, first stage
	logic       sync2;     // Pin synchroniser, second stage
	logic       sync3;     // Previous synchronised level
	logic       tick;

	// Prescaler always runs; taps pick the rate
	always_comb begin
		next_pre = pre + `TMR_PRE_ONE;
		case (i_src)
			`TMR_SRC_OFF:      tick = 1'b0;
			`TMR_SRC_DIV1:     tick = 1'b1;
			`TMR_SRC_DIV8:     tick = ((pre & `TMR_PRE_M8) == `TMR_PRE_M8);
			`TMR_SRC_DIV64:    tick = ((pre & `TMR_PRE_M64) == `TMR_PRE_M64);
			`TMR_SRC_DIV256:   tick = ((pre & `TMR_PRE_M256) == `TMR_PRE_M256);
			`TMR_SRC_DIV1024:  tick = (pre == `TMR_PRE_M1024);
			// Edges only from the settled stages, never the first flop
			`TMR_SRC_EXT_FALL: tick = sync3 & ~sync2;
			`TMR_SRC_EXT_RISE: tick = ~sync3 & sync2;
			default:           tick = 1'b0;
		endcase
	end

	// Register the prescaler and synchroniser
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			pre   <= `TMR_PRE_ZERO;
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else begin
			pre   <= next_pre;
			sync1 <= i_ext_pin;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Combinational enable; stops at once when the source is off
	assign o_tick = tick;

endmodule

// >>> bench/tmr_isr_model.sv
/*
 Interrupt taker model: stands for the processor core that services the
 timer flags and answers with one-cycle acknowledge pulses.
 Assumes the flags are registered levels on the system clock.
*/
`timescale 1ns/100ps

module tmr_isr_model (
	// Clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_nrst,
	// Global interrupt enable from the bench
	input  wire logic i_en,
	// Flags seen
	input  wire logic i_ovf,
	input  wire logic i_cmpa,
	input  wire logic i_cmpb,
	// Acknowledges
	output logic      o_ovf_ack,
	output logic      o_cmpa_ack,
	output logic      o_cmpb_ack
);
	logic [1:0] wait_cnt; // Interrupt entry latency
	logic [2:0] acks;     // One-cycle pulses

	// Takes the interrupt a few cycles after a flag, only while enabled,
	// so wide accesses by the bench are never split by a handler
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			wait_cnt <= 2'h0;
			acks     <= 3'h0;
		end else begin
			acks <= 3'h0;
			if (i_en && (i_ovf || i_cmpa || i_cmpb) && acks == 3'h0) begin
				if (wait_cnt == 2'h3) begin
					acks     <= {i_cmpb, i_cmpa, i_ovf};
					wait_cnt <= 2'h0;
				end else begin
					wait_cnt <= wait_cnt + 2'h1;
				end
			end else begin
				wait_cnt <= 2'h0;
			end
		end
	end

	assign o_ovf_ack  = acks[0];
	assign o_cmpa_ack = acks[1];
	assign o_cmpb_ack = acks[2];
endmodule

// >>> bench/tb.sv
/*
 Testbench for the timer core: byte bus tasks, ticks from the external
 pin source, and mode, flag and wide access sequences.
 Assumes the interrupt model drives the acknowledges.
*/
`timescale 1ns/100ps
`include "tmr_defines.svh"

module tb;
	logic       clk;     // System clock
	logic       nrst;    // Reset, active low
	logic [7:0] addr;    // Bus address
	logic [7:0] wdata;   // Bus write data
	logic       wr;      // Write strobe
	logic       rd;      // Read strobe
	logic       capture; // Capture event
	logic       pin;     // External count pin
	logic       isr_en;  // Interrupts allowed
	logic [7:0] rdata;
	logic       ovf;
	logic       fa;
	logic       fb;
	logic       ack_o;
	logic       ack_a;
	logic       ack_b;
	int         bad_count;
	int         n_checks;
	int         cyc;
	logic [7:0] modes [5] = '{8'h00, 8'h01, 8'h80, 8'h40, 8'hc0};

	tmr_core u_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_ovf_ack(ack_o), .i_cmpa_ack(ack_a), .i_cmpb_ack(ack_b),
		.i_capture(capture), .i_ext_tick_pin(pin), .o_overflow_flag(ovf),
		.o_compare_flag_a(fa), .o_compare_flag_b(fb));

	tmr_isr_model u_isr (.i_clk_sys(clk), .i_nrst(nrst), .i_en(isr_en), .i_ovf(ovf), .i_cmpa(fa),
		.i_cmpb(fb), .o_ovf_ack(ack_o), .o_cmpa_ack(ack_a), .o_cmpb_ack(ack_b));

	// Clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Compare and count
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One-cycle write strobe
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read strobe, data looked at in the following cycle only
	task automatic rreg(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(name, exp, rdata);
	endtask

	// Wide write, high byte first
	task automatic wwide(input logic [7:0] hi_a, input logic [7:0] lo_a, input logic [15:0] v);
		wreg(hi_a, v[15:8]);
		wreg(lo_a, v[7:0]);
	endtask

	// Pin pulses, one tick each; long enough for the synchroniser
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			pin <= 1'b1;
			repeat (4) @(posedge clk);
			pin <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask

	// Verdict, reached from the end of the tests or the hang limit
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Hang limit, far above the few thousand cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			summarize();
		end
	end

	initial begin
		{addr, wdata, wr, rd, capture, pin, isr_en} = '0;
		nrst = 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		// Reset values, unmapped place, reserved bits
		rreg(`TMR_ADDR_CTRL_A, 8'h00, "ctrl_a");
		rreg(`TMR_ADDR_FLAGS, 8'h00, "flags");
		wreg(8'h07, 8'hff);
		rreg(8'h07, 8'h00, "unmapped");
		wreg(`TMR_ADDR_CTRL_A, 8'hff);
		rreg(`TMR_ADDR_CTRL_A, 8'hc1, "ctrl_a bits");
		wreg(`TMR_ADDR_CTRL_B, 8'hff);
		rreg(`TMR_ADDR_CTRL_B, 8'h07, "ctrl_b bits");
		$display("test reset done");
		// Overflow at the top of every mode
		foreach (modes[i]) begin
			wreg(`TMR_ADDR_CTRL_A, modes[i]);
			wreg(`TMR_ADDR_FLAGS, 8'h07);
			wwide(`TMR_ADDR_CNT_HI, `TMR_ADDR_CNT_LO, 16'hffff);
			tick(1);
			rreg(`TMR_ADDR_CNT_LO, 8'h00, "wrap lo");
			rreg(`TMR_ADDR_CNT_HI, 8'h00, "wrap hi");
			chk("ovf", 8'h01, {7'h00, ovf});
		end
		tick(2);
		chk("ovf sticky", 8'h01, {7'h00, ovf});
		isr_en <= 1'b1;
		repeat (10) @(posedge clk);
		isr_en <= 1'b0;
		chk("ovf acked", 8'h00, {7'h00, ovf});
		wreg(`TMR_ADDR_CTRL_B, `TMR_SRC_OFF);
		tick(3);
		rreg(`TMR_ADDR_CNT_LO, 8'h02, "stopped");
		wreg(`TMR_ADDR_CTRL_B, `TMR_SRC_EXT_RISE);
		$display("test modes done");
		// Match blocking after a counter write, flag one tick late
		wreg(`TMR_ADDR_CTRL_A, 8'h00);
		wreg(`TMR_ADDR_CMP_A, 8'h05);
		wreg(`TMR_ADDR_FLAGS, 8'h07);
		wreg(`TMR_ADDR_CNT_LO, 8'h05);
		tick(1);
		chk("blocked", 8'h00, {7'h00, fa});
		wreg(`TMR_ADDR_CNT_LO, 8'h04);
		tick(1);
		chk("not yet", 8'h00, {7'h00, fa});
		tick(1);
		chk("match", 8'h01, {7'h00, fa});
		rreg(`TMR_ADDR_CNT_LO, 8'h06, "count");
		// Compare B equal to the count, flag at the next tick
		wreg(`TMR_ADDR_CMP_B, 8'h06);
		chk("cmp b early", 8'h00, {7'h00, fb});
		tick(1);
		chk("cmp b", 8'h01, {7'h00, fb});
		$display("test compare done");
		// Clear on match, then a top below the count
		wreg(`TMR_ADDR_CTRL_A, 8'h01);
		wreg(`TMR_ADDR_CMP_A, 8'h03);
		wreg(`TMR_ADDR_FLAGS, 8'h07);
		wreg(`TMR_ADDR_CNT_LO, 8'h00);
		tick(4);
		chk("ctc flag", 8'h01, {7'h00, fa});
		rreg(`TMR_ADDR_CNT_LO, 8'h00, "ctc clear");
		wreg(`TMR_ADDR_FLAGS, 8'h07);
		wreg(`TMR_ADDR_CNT_LO, 8'h10);
		tick(240);
		rreg(`TMR_ADDR_CNT_LO, 8'h00, "ctc run on");
		chk("ctc ovf", 8'h01, {7'h00, ovf});
		chk("ctc missed", 8'h00, {7'h00, fa});
		tick(4);
		chk("ctc late", 8'h01, {7'h00, fa});
		$display("test ctc done");
		// Wide access through the shared latch
		wreg(`TMR_ADDR_CTRL_A, 8'h80);
		wwide(`TMR_ADDR_CNT_HI, `TMR_ADDR_CMP_A, 16'h1234);
		rreg(`TMR_ADDR_CMP_A, 8'h34, "cmp lo");
		rreg(`TMR_ADDR_CMP_B, 8'h12, "cmp hi");
		wwide(`TMR_ADDR_CNT_HI, `TMR_ADDR_CNT_LO, 16'h00ff);
		rreg(`TMR_ADDR_CNT_LO, 8'hff, "lo");
		tick(1);
		rreg(`TMR_ADDR_CNT_HI, 8'h00, "latched hi");
		rreg(`TMR_ADDR_CNT_LO, 8'h00, "carry lo");
		rreg(`TMR_ADDR_CNT_HI, 8'h01, "carry hi");
		// Capture value read through the latch
		wreg(`TMR_ADDR_CTRL_B, `TMR_SRC_OFF);
		wreg(`TMR_ADDR_CTRL_A, 8'hc0);
		wwide(`TMR_ADDR_CNT_HI, `TMR_ADDR_CNT_LO, 16'habcd);
		@(posedge clk);
		capture <= 1'b1;
		@(posedge clk);
		capture <= 1'b0;
		wreg(`TMR_ADDR_CNT_HI, 8'h55);
		rreg(`TMR_ADDR_CMP_B, 8'h55, "cap hi early");
		rreg(`TMR_ADDR_CMP_A, 8'hcd, "cap lo");
		rreg(`TMR_ADDR_CMP_B, 8'hab, "cap hi");
		$display("test wide done");
		summarize();
	end
endmodule
